// >>> src/sesp_core.sv
// Select decode, acknowledge and write protect front end with its array

// How it works
// - Only type identifier 1010 selects device
// - Start, select byte, then acknowledge slot
// - Device acknowledges each accepted written byte
// - Ignore bus in reset; standby after
// - Chip select pins match bits b3..b1
// - Write protect high from start to end of address blocks writes
// - Unconnected write protect reads as low
// - Protected: ack select and address, nack data
// - Select byte arrives most significant first
// - Larger variants take address from select
// - Byte wide array, capacity-dependent depth
// - Single byte and sixteen-byte page writes
// - All activity follows master serial clock
// - Data line only pulled low or released
// - Works at serial clocks to 400kHz
// - Last select bit: one read, zero write
// - Mismatch: release line, back to standby
// - Programming starts only on Stop after ack
// - During programming ignore both lines
module sesp_core
  import sesp_pkg::*;
#(
  parameter int CAP_KBIT = SESP_CAP_KBIT,
  parameter int WCYC_CYC = SESP_WCYC_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  input wire logic write_protect_input,
  output logic busy_programming,
  output logic selected
);

  localparam int DEPTH = CAP_KBIT * 128;
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (!(CAP_KBIT inside {1, 2, 4, 8, 16}))
      $error("capacity must be 1, 2, 4, 8 or 16 kbit");
    if (WCYC_CYC < 1)
      $error("write cycle count must be at least one");
  end

  // ----------------------------------------------------------------
  // Synchronisers and condition detect
  // ----------------------------------------------------------------
  sesp_lines_type s1_reg, s2_reg, s3_reg;
  sesp_lines_type s1_next, s2_next, s3_next;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  // two flops then edge detect on the master clock
  always_comb begin
    // Protect and strap pins are asynchronous too
    s1_next = '{scl: scl_in, sda: sda_in, wp: write_protect_input,
      cs: {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0}};
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= SESP_LINES_RST;
      s2_reg <= SESP_LINES_RST;
      s3_reg <= SESP_LINES_RST;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  // 200 MHz sampling covers 400 kHz timing easily
  assign scl_rise = s2_reg.scl & ~s3_reg.scl;
  assign scl_fall = ~s2_reg.scl & s3_reg.scl;
  assign start_seen = s2_reg.scl & s3_reg.scl & s3_reg.sda & ~s2_reg.sda;
  assign stop_seen = s2_reg.scl & s3_reg.scl & ~s3_reg.sda & s2_reg.sda;

  // ----------------------------------------------------------------
  // Select decode
  // ----------------------------------------------------------------
  // Chip select bits not borrowed for addressing must match the pins
  function automatic logic sel_match(input logic [7:0] b,
                                     input logic [2:0] pins);
    logic ok;
    ok = (b[SESP_ID_MSB:SESP_ID_LSB] == SESP_TYPE_ID);
    if (CAP_KBIT < 4 && b[1] != pins[0]) ok = 1'b0;
    if (CAP_KBIT < 8 && b[2] != pins[1]) ok = 1'b0;
    if (CAP_KBIT < 16 && b[3] != pins[2]) ok = 1'b0;
    return ok;
  endfunction

  // ----------------------------------------------------------------
  // Link state
  // ----------------------------------------------------------------
  sesp_phase_type phase_reg, phase_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] hi_reg, hi_next;
  logic [7:0] lo_reg, lo_next;
  logic ack_reg, ack_next;
  logic acked_reg, acked_next;
  logic wp_reg, wp_next;
  logic [4:0] pend_reg, pend_next;
  logic [31:0] wcnt_reg, wcnt_next;
  logic [7:0] rd_reg, rd_next;
  logic drive_low_reg, drive_low_next;
  logic wr_en;
  logic [AW-1:0] addr;
  logic [7:0] mem [DEPTH];

  assign addr = AW'({hi_reg, lo_reg});

  always_comb begin
    phase_next = phase_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    ack_next = ack_reg;
    acked_next = acked_reg;
    wp_next = wp_reg;
    pend_next = pend_reg;
    wcnt_next = wcnt_reg;
    rd_next = rd_reg;
    drive_low_next = drive_low_reg;
    wr_en = 1'b0;
    if (phase_reg == SESP_PROGRAM) begin
      // lines ignored while the array programs
      drive_low_next = 1'b0;
      if (wcnt_reg == 32'(WCYC_CYC - 1)) begin
        phase_next = SESP_IDLE;
        wcnt_next = '0;
      end else begin
        wcnt_next = wcnt_reg + 32'h1;
      end
    end else if (start_seen) begin
      // each transaction opens with a select byte
      phase_next = SESP_SELECT;
      bit_next = SESP_BIT_START;
      ack_next = 1'b0;
      acked_next = 1'b0;
      drive_low_next = 1'b0;
      // an idle-low pin lets writes through
      wp_next = s2_reg.wp;
    end else if (stop_seen) begin
      // program only when stop follows an acked slot
      if (phase_reg == SESP_WDATA && acked_reg && bit_reg == SESP_BIT_RST
          && pend_reg != 5'h0 && !wp_reg)
        phase_next = SESP_PROGRAM;
      else
        phase_next = SESP_IDLE;
      pend_next = '0;
      drive_low_next = 1'b0;
    end else if (phase_reg != SESP_IDLE) begin
      if (scl_rise) begin
        if (bit_reg == SESP_ACK_SLOT) begin
          // master no-ack ends the read stream
          if (phase_reg == SESP_RDATA && s2_reg.sda)
            phase_next = SESP_IDLE;
        end else begin
          // shift in most significant bit first
          shift_next = {shift_reg[6:0], s2_reg.sda};
        end
        // protect held from start to end of address
        if (phase_reg == SESP_SELECT || phase_reg == SESP_ADDR)
          wp_next = wp_reg | s2_reg.wp;
      end
      if (scl_fall) begin
        drive_low_next = 1'b0;
        // acked slot passed; survives the tenth-slot rise
        acked_next = (bit_reg == SESP_ACK_SLOT) && ack_reg;
        if (bit_reg == 4'h7) begin
          bit_next = SESP_ACK_SLOT;
          case (phase_reg)
            SESP_SELECT: begin
              ack_next = sel_match(shift_reg, s2_reg.cs);
              // borrowed select bits become high address
              if (CAP_KBIT >= 4) hi_next[0] = shift_reg[1];
              if (CAP_KBIT >= 8) hi_next[1] = shift_reg[2];
              if (CAP_KBIT >= 16) hi_next[2] = shift_reg[3];
            end
            SESP_ADDR: begin
              ack_next = 1'b1;
              lo_next = shift_reg;
            end
            SESP_WDATA: begin
              // data bytes get no-ack when protected
              ack_next = !wp_reg;
              // page of sixteen, low nibble wraps
              if (!wp_reg) begin
                wr_en = 1'b1;
                lo_next = {lo_reg[7:4], lo_reg[3:0] + 4'h1};
                if (pend_reg != SESP_PAGE_BYTES)
                  pend_next = pend_reg + 5'h1;
              end
            end
            default: ack_next = 1'b0;
          endcase
          // pull low in ninth slot for accepted bytes
          drive_low_next = (phase_reg != SESP_RDATA) && ack_next;
        end else if (bit_reg == SESP_ACK_SLOT) begin
          bit_next = SESP_BIT_RST;
          case (phase_reg)
            SESP_SELECT: begin
              if (!ack_reg)
                phase_next = SESP_IDLE;
              else if (shift_reg[SESP_RW_BIT] == SESP_RW_READ)
                phase_next = SESP_RDATA;
              else
                phase_next = SESP_ADDR;
            end
            SESP_ADDR: phase_next = SESP_WDATA;
            default: phase_next = phase_reg;
          endcase
          if (phase_next == SESP_RDATA) begin
            rd_next = mem[addr];
            lo_next = lo_reg + 8'h1;
            drive_low_next = ~mem[addr][7];
          end
        end else begin
          bit_next = bit_reg + 4'h1;
          if (phase_reg == SESP_RDATA)
            drive_low_next = ~rd_reg[3'(6 - bit_reg)];
        end
      end
    end
  end

  // reset holds standby and silences the line
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= SESP_IDLE;
      bit_reg <= SESP_BIT_RST;
      shift_reg <= '0;
      hi_reg <= '0;
      lo_reg <= '0;
      ack_reg <= 1'b0;
      acked_reg <= 1'b0;
      wp_reg <= 1'b0;
      pend_reg <= '0;
      wcnt_reg <= '0;
      rd_reg <= '0;
      drive_low_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      ack_reg <= ack_next;
      acked_reg <= acked_next;
      wp_reg <= wp_next;
      pend_reg <= pend_next;
      wcnt_reg <= wcnt_next;
      rd_reg <= rd_next;
      drive_low_reg <= drive_low_next;
    end
  end

  // Array written at the byte boundary; latched page data is simplified
  always_ff @(posedge clk) begin
    if (wr_en)
      mem[addr] <= shift_reg;
  end

  // open drain, output value fixed low
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg;
  assign busy_programming = (phase_reg == SESP_PROGRAM);
  assign selected = (phase_reg != SESP_IDLE) && (phase_reg != SESP_PROGRAM);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_no_drive_high;
    @(posedge clk) disable iff (!arst_n) sda_oe |-> !sda_out;
  endproperty
  a_no_drive_high: assert property (p_no_drive_high)
    else $error("data line driven high");

  property p_quiet_program;
    @(posedge clk) disable iff (!arst_n)
      busy_programming |-> !sda_oe;
  endproperty
  a_quiet_program: assert property (p_quiet_program)
    else $error("line driven while programming");

  property p_bad_id;
    @(posedge clk) disable iff (!arst_n)
      (phase_reg == SESP_SELECT && scl_fall && bit_reg == 4'h7
       && shift_reg[7:4] != SESP_TYPE_ID) |=> !ack_reg && !sda_oe;
  endproperty
  a_bad_id: assert property (p_bad_id)
    else $error("foreign identifier acknowledged");

  property p_pins;
    @(posedge clk) disable iff (!arst_n)
      (phase_reg == SESP_SELECT && scl_fall && bit_reg == 4'h7
       && CAP_KBIT < 4 && shift_reg[1] != s2_reg.cs[0]) |=> !ack_reg;
  endproperty
  a_pins: assert property (p_pins)
    else $error("chip select mismatch acknowledged");

  property p_wp_nack;
    @(posedge clk) disable iff (!arst_n)
      (phase_reg == SESP_WDATA && wp_reg && scl_fall && bit_reg == 4'h7)
      |=> !sda_oe;
  endproperty
  a_wp_nack: assert property (p_wp_nack)
    else $error("protected data byte acknowledged");

  property p_wp_store;
    @(posedge clk) disable iff (!arst_n) wr_en |-> !wp_reg;
  endproperty
  a_wp_store: assert property (p_wp_store)
    else $error("write under protection");

  property p_program_cause;
    @(posedge clk) disable iff (!arst_n)
      $rose(busy_programming) |-> $past(stop_seen) && $past(acked_reg);
  endproperty
  a_program_cause: assert property (p_program_cause)
    else $error("programming without stop after ack");

  property p_mismatch_idle;
    @(posedge clk) disable iff (!arst_n)
      (phase_reg == SESP_SELECT && bit_reg == SESP_ACK_SLOT && !ack_reg
       && scl_fall && !start_seen && !stop_seen) |=> phase_reg == SESP_IDLE;
  endproperty
  a_mismatch_idle: assert property (p_mismatch_idle)
    else $error("unselected device stayed active");

  property p_ack_slot;
    @(posedge clk) disable iff (!arst_n)
      sda_oe && phase_reg != SESP_RDATA |-> bit_reg == SESP_ACK_SLOT;
  endproperty
  a_ack_slot: assert property (p_ack_slot)
    else $error("acknowledge outside ninth slot");

  c_select: cover property (@(posedge clk) phase_reg == SESP_ADDR);
  c_read: cover property (@(posedge clk) phase_reg == SESP_RDATA);
  c_program: cover property (@(posedge clk) $rose(busy_programming));
  c_wp: cover property (@(posedge clk) phase_reg == SESP_WDATA && wp_reg);

endmodule

// >>> src/sesp_pkg.sv
// Shared constants and types for the two-wire memory select front end
package sesp_pkg;

  // ----------------------------------------------------------------
  // Select byte layout
  // ----------------------------------------------------------------
  localparam logic [3:0] SESP_TYPE_ID = 4'ha;
  localparam int SESP_ID_MSB = 7;
  localparam int SESP_ID_LSB = 4;
  localparam int SESP_CS_MSB = 3;
  localparam int SESP_CS_LSB = 1;
  localparam int SESP_RW_BIT = 0;
  localparam logic SESP_RW_READ = 1'b1;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] SESP_ACK_SLOT = 4'h8;
  localparam logic [3:0] SESP_BIT_RST = 4'h0;
  // Start's own clock fall wraps this to zero, so it is not a bit
  localparam logic [3:0] SESP_BIT_START = 4'hf;
  localparam logic [4:0] SESP_PAGE_BYTES = 5'h10;
  localparam int SESP_CAP_KBIT = 16;
  localparam int SESP_WCYC_NS = 5000000;
  localparam int SESP_CLK_NS = 5;
  localparam int SESP_WCYC_CYC = SESP_WCYC_NS / SESP_CLK_NS;

  // ----------------------------------------------------------------
  // Link phases
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SESP_IDLE, SESP_SELECT, SESP_ADDR, SESP_WDATA, SESP_RDATA,
    SESP_PROGRAM
  } sesp_phase_type;

  // Pin levels passed through the synchroniser
  typedef struct packed {
    logic scl;
    logic sda;
    logic wp;
    logic [2:0] cs;
  } sesp_lines_type;

  // Idle bus lines high, protect low so writes pass by default
  localparam sesp_lines_type SESP_LINES_RST = '{
    scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0
  };

endpackage

// >>> testbench/sesp_core_bench.sv
// Self-checking bench for the select, acknowledge and protect front end
module sesp_core_bench import sesp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [2:0] CS = 3'h5;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wp = 1'b0;
  logic scl, m_low, sda, sda_out, sda_oe, busy, sel, a, r;
  logic [7:0] d;
  int error_cnt = 0;
  int cmp_count = 0;

  // Pull-up wins unless someone pulls the data line low
  assign sda = !(m_low || (sda_oe && !sda_out));

  // 200 MHz system clock
  always #2.5 clk = !clk;

  sesp_core #(.CAP_KBIT(2), .WCYC_CYC(600)) u_sesp_core (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_pin_0(CS[0]), .chip_select_pin_1(CS[1]),
    .chip_select_pin_2(CS[2]), .write_protect_input(wp),
    .busy_programming(busy), .selected(sel)
  );

  sesp_master_model u_sesp_master_model (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(m_low)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic open_t(input logic [3:0] id, input logic [2:0] cs,
                        input logic rw, output logic ack);
    u_sesp_master_model.start_c();
    u_sesp_master_model.wr_byte({id, cs, rw}, ack);
  endtask

  task automatic wr(input logic [7:0] v, output logic ack);
    u_sesp_master_model.wr_byte(v, ack);
  endtask

  task automatic stop();
    u_sesp_master_model.stop_c();
  endtask

  // Hang guard, far beyond the few thousand clocks the tests take
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    chk({5'h0, sda_oe, busy, sel}, 8'h00);
    arst_n <= 1'b1;
    repeat (5) @(posedge clk);
    // Foreign identifiers, then a chip-select mismatch
    // Step of three never lands on the valid identifier
    for (int i = 0; i < 16; i += 3) begin
      open_t(4'(i), CS, 1'b0, a);
      chk({7'h0, a}, 8'h00);
      chk({7'h0, sel}, 8'h00);
      stop();
    end
    open_t(SESP_TYPE_ID, 3'h4, 1'b0, a);
    chk({7'h0, a}, 8'h00);
    stop();
    // Two-byte page write, then a request while programming
    open_t(SESP_TYPE_ID, CS, 1'b0, a);
    chk({7'h0, a}, 8'h01);
    wr(8'h10, a);
    chk({7'h0, a}, 8'h01);
    wr(8'h5a, a);
    chk({7'h0, a}, 8'h01);
    wr(8'hc3, a);
    chk({7'h0, a}, 8'h01);
    stop();
    chk({7'h0, busy}, 8'h01);
    open_t(SESP_TYPE_ID, CS, 1'b0, a);
    chk({7'h0, a}, 8'h00);
    stop();
    for (int i = 0; i < 800 && busy; i++)
      @(posedge clk);
    chk({7'h0, busy}, 8'h00);
    // Protect seen in address phase holds after it drops
    wp <= 1'b1;
    open_t(SESP_TYPE_ID, CS, 1'b0, a);
    chk({7'h0, a}, 8'h01);
    wr(8'h10, a);
    chk({7'h0, a}, 8'h01);
    wp <= 1'b0;
    wr(8'h33, a);
    chk({7'h0, a}, 8'h00);
    stop();
    chk({7'h0, busy}, 8'h00);
    // Stop in mid-byte must not program
    open_t(SESP_TYPE_ID, CS, 1'b0, a);
    wr(8'h10, a);
    repeat (4) u_sesp_master_model.bit_x(1'b0, r);
    stop();
    chk({7'h0, busy}, 8'h00);
    // Address set with no data, then read back
    open_t(SESP_TYPE_ID, CS, 1'b0, a);
    wr(8'h10, a);
    stop();
    chk({7'h0, busy}, 8'h00);
    open_t(SESP_TYPE_ID, CS, 1'b1, a);
    chk({7'h0, a}, 8'h01);
    u_sesp_master_model.rd_byte(1'b0, d);
    chk(d, 8'h5a);
    u_sesp_master_model.rd_byte(1'b1, d);
    chk(d, 8'hc3);
    stop();
    conclude();
  end
endmodule

// >>> testbench/sesp_master_model.sv
// Bus master model driving the serial clock and open-drain data line
module sesp_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // A quarter of the 125 ns serial period is about six clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic start_c();
    sda_low <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(6);
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b0;
    tick(6);
  endtask

  // Data changes only while the clock is low, sampled mid-high
  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    tick(6);
    scl <= 1'b1;
    tick(6);
    r = sda;
    tick(6);
    scl <= 1'b0;
    tick(7);
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask
endmodule
